// file: hdl/line_termination_equalizer_ctrl.sv
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module line_termination_equalizer_ctrl #(
	parameter int PEAK_W = 8
) (
	input  wire logic              clock,
	input  wire logic              nrst,
	// Register port
	input  wire logic [7:0]        reg_addr,
	input  wire logic [7:0]        reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [7:0]        reg_rdata,
	// Control mode and pins
	input  wire logic              hw_mode,
	input  wire logic              t1j1_mode,
	input  wire logic              soft_reset,
	input  wire logic              driver_float,
	input  wire logic              impedance_network_pin,
	input  wire logic [1:0]        pattern_select_pins,
	input  wire logic              boost_gain_pin,
	input  wire logic              mclk_lost,
	input  wire logic              tx_clock_lost,
	input  wire logic              remote_loopback,
	input  wire logic              pattern_on_mclk,
	// Receive front end
	input  wire logic              symbol_tick,
	input  wire logic [PEAK_W-1:0] rx_peak,
	// Outputs
	output logic                   tx_internal_term,
	output logic      [1:0]        tx_impedance,
	output logic      [3:0]        pulse_shape_code,
	output logic                   rx_internal_term,
	output logic      [1:0]        rx_impedance,
	output logic                   tx_line_pair_oe,
	output logic                   tx_powered,
	output logic      [1:0]        boost_gain,
	output logic                   equalizer_enable,
	output logic      [4:0]        eq_step,
	output logic                   equalizer_out_of_range,
	output logic                   irq
);

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	logic [7:0] imp_ff, nxt_imp;
	logic [7:0] tca_ff, nxt_tca;
	logic [7:0] tcb_ff, nxt_tcb;
	logic [7:0] eqc_ff, nxt_eqc;
	logic [7:0] mwc_ff, nxt_mwc;
	logic [7:0] msk_ff, nxt_msk;
	logic [7:0] ies_ff, nxt_ies;
	logic       flag_ff, nxt_flag;
	logic       oor_ff, nxt_oor;
	logic [4:0] step_ff, nxt_step;
	logic [7:0] rdata_ff, nxt_rdata;
	logic       rst_float_ff, nxt_rst_float;

	// Register writes; a software reset restores defaults
	always_comb begin
		nxt_imp = imp_ff;
		nxt_tca = tca_ff;
		nxt_tcb = tcb_ff;
		nxt_eqc = eqc_ff;
		nxt_mwc = mwc_ff;
		nxt_msk = msk_ff;
		nxt_ies = ies_ff;
		if (soft_reset) begin
			nxt_imp = line_term_eq_pkg::RST_LINE_IMPEDANCE_SELECT;
			nxt_tca = line_term_eq_pkg::RST_TRANSMIT_CONFIG_A;
			nxt_tcb = line_term_eq_pkg::RST_TRANSMIT_CONFIG_B;
			nxt_eqc = line_term_eq_pkg::RST_RX_EQUALIZER_CONFIG;
			nxt_mwc = line_term_eq_pkg::RST_RX_MONITOR_WINDOW;
			nxt_msk = line_term_eq_pkg::RST_INTERRUPT_MASK;
			nxt_ies = line_term_eq_pkg::RST_INTERRUPT_EDGE_SELECT;
		end else if (reg_wr) begin
			unique case (reg_addr)
				line_term_eq_pkg::ADDR_LINE_IMPEDANCE_SELECT:    nxt_imp = {2'h0, reg_wdata[5:0]};
				line_term_eq_pkg::ADDR_TRANSMIT_CONFIG_A:        nxt_tca = {7'h00, reg_wdata[0]};
				line_term_eq_pkg::ADDR_TRANSMIT_CONFIG_B:        nxt_tcb = {7'h00, reg_wdata[0]};
				line_term_eq_pkg::ADDR_RX_EQUALIZER_CONFIG:      nxt_eqc = {7'h00, reg_wdata[0]};
				line_term_eq_pkg::ADDR_RX_MONITOR_WINDOW_CONFIG: nxt_mwc = {4'h0, reg_wdata[3:0]};
				line_term_eq_pkg::ADDR_INTERRUPT_MASK:           nxt_msk = {7'h00, reg_wdata[0]};
				line_term_eq_pkg::ADDR_INTERRUPT_EDGE_SELECT:    nxt_ies = {7'h00, reg_wdata[0]};
				default: begin
				end
			endcase
		end
	end

	// Register file storage, defaults on pin reset
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			imp_ff <= line_term_eq_pkg::RST_LINE_IMPEDANCE_SELECT;
			tca_ff <= line_term_eq_pkg::RST_TRANSMIT_CONFIG_A;
			tcb_ff <= line_term_eq_pkg::RST_TRANSMIT_CONFIG_B;
			eqc_ff <= line_term_eq_pkg::RST_RX_EQUALIZER_CONFIG;
			mwc_ff <= line_term_eq_pkg::RST_RX_MONITOR_WINDOW;
			msk_ff <= line_term_eq_pkg::RST_INTERRUPT_MASK;
			ies_ff <= line_term_eq_pkg::RST_INTERRUPT_EDGE_SELECT;
		end else begin
			imp_ff <= nxt_imp;
			tca_ff <= nxt_tca;
			tcb_ff <= nxt_tcb;
			eqc_ff <= nxt_eqc;
			mwc_ff <= nxt_mwc;
			msk_ff <= nxt_msk;
			ies_ff <= nxt_ies;
		end
	end

	// ----------------------------------------
	// Termination and gain selection
	// ----------------------------------------
	logic [2:0] tx_code;
	logic [2:0] rx_code;
	logic       tx_off;
	logic       float_req;

	// Software field or pin decides termination, gain and power-down
	always_comb begin
		tx_code = imp_ff[line_term_eq_pkg::TX_TERM_LSB +: 3];
		rx_code = imp_ff[line_term_eq_pkg::RX_TERM_LSB +: 3];
		tx_impedance = tx_code[1:0];
		rx_impedance = rx_code[1:0];
		// External transmit matching is refused in T1/J1
		tx_internal_term = !tx_code[2] || t1j1_mode;
		rx_internal_term = !rx_code[2];
		unique case (tx_code[1:0])
			2'h0:    pulse_shape_code = line_term_eq_pkg::PULSE_E1_75;
			2'h1:    pulse_shape_code = line_term_eq_pkg::PULSE_E1_120;
			2'h2:    pulse_shape_code = line_term_eq_pkg::PULSE_T1;
			2'h3:    pulse_shape_code = line_term_eq_pkg::PULSE_J1;
		endcase
		boost_gain = mwc_ff[line_term_eq_pkg::GAIN_LSB +: 2];
		tx_off = tca_ff[line_term_eq_pkg::TX_OFF_BIT];
		float_req = tcb_ff[line_term_eq_pkg::FLOAT_BIT];
		if (hw_mode) begin
			// Pulse shape pins pick the impedance value outside this block
			tx_internal_term = !impedance_network_pin || t1j1_mode;
			rx_internal_term = !impedance_network_pin;
			boost_gain = boost_gain_pin ? line_term_eq_pkg::GAIN_26DB
			                            : line_term_eq_pkg::GAIN_0DB;
			tx_off = (pattern_select_pins == line_term_eq_pkg::PATTERN_TX_OFF);
			float_req = 1'b0;
		end
	end

	// ----------------------------------------
	// Transmit driver float
	// ----------------------------------------
	// Holds the pair floating through the first cycle after any reset
	always_comb begin
		nxt_rst_float = soft_reset;
	end

	// Float marker, set by pin reset and by a software reset
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rst_float_ff <= 1'b1;
		end else begin
			rst_float_ff <= nxt_rst_float;
		end
	end

	// Driver enables only when no float cause stands
	always_comb begin
		tx_powered = !tx_off;
		// Software reset floats the pair already in the cycle it is raised
		tx_line_pair_oe = !(driver_float || float_req
		                  || tx_off
		                  || soft_reset || rst_float_ff || mclk_lost
		                  || (tx_clock_lost && !remote_loopback && !pattern_on_mclk));
	end

	// ----------------------------------------
	// Observation window and equalizer
	// ----------------------------------------
	logic [8:0]        win_cnt_ff, nxt_win_cnt;
	logic [PEAK_W-1:0] peak_ff, nxt_peak;
	logic [8:0]        win_len;
	logic [7:0]        peak_top;

	// Window length in symbols from the window field
	always_comb begin
		unique case (mwc_ff[line_term_eq_pkg::WINDOW_LSB +: 2])
			2'h0:    win_len = line_term_eq_pkg::WIN_32;
			2'h1:    win_len = line_term_eq_pkg::WIN_64;
			2'h2:    win_len = line_term_eq_pkg::WIN_128;
			2'h3:    win_len = line_term_eq_pkg::WIN_256;
		endcase
	end

	// Peak capture per window and step update at its end
	always_comb begin
		equalizer_enable = eqc_ff[line_term_eq_pkg::EQ_EN_BIT];
		peak_top = peak_ff[PEAK_W-1 -: 8];
		nxt_win_cnt = win_cnt_ff;
		nxt_peak = peak_ff;
		nxt_step = step_ff;
		nxt_oor = oor_ff;
		if (!equalizer_enable) begin
			nxt_win_cnt = 9'h000;
			nxt_peak = '0;
			nxt_oor = 1'b0;
		end else if (symbol_tick) begin
			// Last symbol of the window: judge the peak
			if (win_cnt_ff >= win_len - 9'h001) begin
				nxt_win_cnt = 9'h000;
				nxt_peak = '0;
				nxt_oor = 1'b0;
				if (peak_top < line_term_eq_pkg::PEAK_LOW) begin
					if (step_ff == line_term_eq_pkg::EQ_STEP_MAX) begin
						nxt_oor = 1'b1;
					end else begin
						nxt_step = step_ff + 5'h01;
					end
				end else if (peak_top > line_term_eq_pkg::PEAK_HIGH) begin
					if (step_ff == 5'h00) begin
						nxt_oor = 1'b1;
					end else begin
						nxt_step = step_ff - 5'h01;
					end
				end
			end else begin
				// Mid window: count and track the largest sample
				nxt_win_cnt = win_cnt_ff + 9'h001;
				if (rx_peak > peak_ff) begin
					nxt_peak = rx_peak;
				end
			end
		end
	end

	// Equalizer state storage; the step survives a disable
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			win_cnt_ff <= 9'h000;
			peak_ff <= '0;
			step_ff <= 5'h00;
			oor_ff <= 1'b0;
		end else begin
			win_cnt_ff <= nxt_win_cnt;
			peak_ff <= nxt_peak;
			step_ff <= nxt_step;
			oor_ff <= nxt_oor;
		end
	end

	// Status outputs straight from flip-flops
	always_comb begin
		eq_step = step_ff;
		equalizer_out_of_range = oor_ff;
	end

	// ----------------------------------------
	// Event flag and read port
	// ----------------------------------------
	logic event_hit;
	logic flag_rd;

	// New event wins over the clearing read
	always_comb begin
		event_hit = ies_ff[line_term_eq_pkg::EQ_EVENT_BIT] ? (nxt_oor != oor_ff)
		                                                    : (nxt_oor && !oor_ff);
		flag_rd = reg_rd && (reg_addr == line_term_eq_pkg::ADDR_INTERRUPT_FLAGS);
		nxt_flag = flag_ff;
		if (flag_rd) begin
			nxt_flag = 1'b0;
		end
		if (event_hit && !msk_ff[line_term_eq_pkg::EQ_EVENT_BIT]) begin
			nxt_flag = 1'b1;
		end
		if (soft_reset) begin
			nxt_flag = 1'b0;
		end
		irq = flag_ff;
	end

	// ----------------------------------------
	// Read data path
	// ----------------------------------------
	// Read mux registered for the cycle after the strobe
	always_comb begin
		nxt_rdata = 8'h00;
		if (reg_rd) begin
			unique case (reg_addr)
				line_term_eq_pkg::ADDR_LINE_IMPEDANCE_SELECT:    nxt_rdata = imp_ff;
				line_term_eq_pkg::ADDR_TRANSMIT_CONFIG_A:        nxt_rdata = tca_ff;
				line_term_eq_pkg::ADDR_TRANSMIT_CONFIG_B:        nxt_rdata = tcb_ff;
				line_term_eq_pkg::ADDR_RX_EQUALIZER_CONFIG:      nxt_rdata = eqc_ff;
				line_term_eq_pkg::ADDR_RX_MONITOR_WINDOW_CONFIG: nxt_rdata = mwc_ff;
				line_term_eq_pkg::ADDR_INTERRUPT_MASK:           nxt_rdata = msk_ff;
				line_term_eq_pkg::ADDR_INTERRUPT_EDGE_SELECT:    nxt_rdata = ies_ff;
				line_term_eq_pkg::ADDR_LINE_STATUS:              nxt_rdata = {7'h00, oor_ff};
				line_term_eq_pkg::ADDR_ATTENUATION_STATUS:       nxt_rdata = {3'h0, step_ff};
				line_term_eq_pkg::ADDR_INTERRUPT_FLAGS:          nxt_rdata = {7'h00, flag_ff};
				default:                                         nxt_rdata = 8'h00;
			endcase
		end
	end

	// Event flag and read data storage
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			flag_ff <= 1'b0;
			rdata_ff <= 8'h00;
		end else begin
			flag_ff <= nxt_flag;
			rdata_ff <= nxt_rdata;
		end
	end

	// Read data stands one cycle, zero otherwise
	always_comb begin
		reg_rdata = rdata_ff;
	end

endmodule

`default_nettype wire

// file: hdl/line_term_eq_pkg.sv
package line_term_eq_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] ADDR_LINE_IMPEDANCE_SELECT    = 8'h02;
	localparam logic [7:0] ADDR_TRANSMIT_CONFIG_A        = 8'h04;
	localparam logic [7:0] ADDR_TRANSMIT_CONFIG_B        = 8'h05;
	localparam logic [7:0] ADDR_RX_EQUALIZER_CONFIG      = 8'h0a;
	localparam logic [7:0] ADDR_RX_MONITOR_WINDOW_CONFIG = 8'h0b;
	localparam logic [7:0] ADDR_INTERRUPT_MASK           = 8'h14;
	localparam logic [7:0] ADDR_INTERRUPT_EDGE_SELECT    = 8'h15;
	localparam logic [7:0] ADDR_LINE_STATUS              = 8'h16;
	localparam logic [7:0] ADDR_ATTENUATION_STATUS       = 8'h17;
	localparam logic [7:0] ADDR_INTERRUPT_FLAGS          = 8'h18;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int TX_TERM_LSB  = 0;   // line_impedance_select[2:0]
	localparam int RX_TERM_LSB  = 3;   // line_impedance_select[5:3]
	localparam int TX_OFF_BIT   = 0;   // transmit_config_a
	localparam int FLOAT_BIT    = 0;   // transmit_config_b
	localparam int EQ_EN_BIT    = 0;   // rx_equalizer_config
	localparam int GAIN_LSB     = 0;   // rx_monitor_window_config[1:0]
	localparam int WINDOW_LSB   = 2;   // rx_monitor_window_config[3:2]
	localparam int EQ_EVENT_BIT = 0;   // edge select, mask, status, flags

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] RST_LINE_IMPEDANCE_SELECT = 8'h00;
	localparam logic [7:0] RST_TRANSMIT_CONFIG_A     = 8'h00;
	localparam logic [7:0] RST_TRANSMIT_CONFIG_B     = 8'h00;
	localparam logic [7:0] RST_RX_EQUALIZER_CONFIG   = 8'h00;
	localparam logic [7:0] RST_RX_MONITOR_WINDOW     = 8'h08; // Window code 2'h2
	localparam logic [7:0] RST_INTERRUPT_MASK        = 8'h01; // Masked
	localparam logic [7:0] RST_INTERRUPT_EDGE_SELECT = 8'h00;

	// ----------------------------------------
	// Codes
	// ----------------------------------------
	localparam logic [2:0] TERM_E1_75  = 3'h0;
	localparam logic [2:0] TERM_E1_120 = 3'h1;
	localparam logic [2:0] TERM_T1     = 3'h2;
	localparam logic [2:0] TERM_J1     = 3'h3;
	localparam logic [3:0] PULSE_E1_75  = 4'h0;
	localparam logic [3:0] PULSE_E1_120 = 4'h1;
	localparam logic [3:0] PULSE_T1     = 4'h2;
	localparam logic [3:0] PULSE_J1     = 4'h7;
	localparam logic [1:0] IMP_75  = 2'h0;
	localparam logic [1:0] IMP_100 = 2'h1;
	localparam logic [1:0] IMP_110 = 2'h2;
	localparam logic [1:0] IMP_120 = 2'h3;
	localparam logic [1:0] GAIN_0DB  = 2'h0;
	localparam logic [1:0] GAIN_26DB = 2'h2;
	localparam logic [1:0] PATTERN_TX_OFF = 2'h3;

	// ----------------------------------------
	// Observation window lengths in symbols
	// ----------------------------------------
	localparam logic [8:0] WIN_32  = 9'h020;
	localparam logic [8:0] WIN_64  = 9'h040;
	localparam logic [8:0] WIN_128 = 9'h080;
	localparam logic [8:0] WIN_256 = 9'h100;

	// Equalizer step range and adjust thresholds
	localparam logic [4:0] EQ_STEP_MAX  = 5'h1f;
	localparam logic [7:0] PEAK_LOW     = 8'h60;
	localparam logic [7:0] PEAK_HIGH    = 8'ha0;

endpackage

// file: dv/line_side_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Cable end: a symbol every other cycle at a commanded peak amplitude
// ----------------------------------------
module line_side_model (
	input  wire logic       clock,
	input  wire logic       nrst,
	input  wire logic [7:0] level,
	output logic            symbol_tick,
	output logic      [7:0] rx_peak
);
	// Off-symbol samples carry the inverse so a stale peak is never mistaken for data
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			symbol_tick <= 1'b0;
			rx_peak     <= 8'h00;
		end else begin
			symbol_tick <= !symbol_tick;
			rx_peak     <= symbol_tick ? ~level : level;
		end
	end
endmodule
`default_nettype wire

// file: dv/line_term_eq_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module line_term_eq_asserts (
	input wire logic       clock, nrst, reg_rd, hw_mode, t1j1_mode, soft_reset, driver_float,
	input wire logic       impedance_network_pin, boost_gain_pin, mclk_lost, tx_clock_lost,
	input wire logic       remote_loopback, pattern_on_mclk, tx_internal_term, rx_internal_term,
	input wire logic       tx_line_pair_oe, tx_powered, equalizer_enable, equalizer_out_of_range, irq,
	input wire logic [7:0] reg_addr,
	input wire logic [1:0] pattern_select_pins, tx_impedance, boost_gain,
	input wire logic [3:0] pulse_shape_code
);
	logic oor_d_ff;
	logic oor_d2_ff;

	// Status history, to tie a new event to a status change
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			oor_d_ff  <= 1'b0;
			oor_d2_ff <= 1'b0;
		end else begin
			oor_d_ff  <= equalizer_out_of_range;
			oor_d2_ff <= oor_d_ff;
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);

	sequence flag_read;
		reg_rd && reg_addr == 8'h18;
	endsequence
	sequence eq_idle;
		!equalizer_enable [*2];
	endsequence

	chk_float_pin: assert property (driver_float |-> !tx_line_pair_oe)
		else $error("line pair driven while float pin high");
	chk_mclk_loss: assert property ((mclk_lost || soft_reset) |-> !tx_line_pair_oe)
		else $error("line pair driven on clock loss or soft reset");
	chk_tclk_loss: assert property ((tx_clock_lost && !remote_loopback && !pattern_on_mclk) |-> !tx_line_pair_oe)
		else $error("line pair driven without transmit clock");
	chk_pin_power: assert property ((hw_mode && pattern_select_pins == 2'h3) |-> !tx_powered && !tx_line_pair_oe)
		else $error("pattern pins 11 left transmitter on");
	chk_pin_gain: assert property (hw_mode |-> boost_gain == (boost_gain_pin ? 2'h2 : 2'h0))
		else $error("pin gain wrong");
	chk_pin_term: assert property (hw_mode |-> rx_internal_term == !impedance_network_pin
		&& tx_internal_term == (!impedance_network_pin || t1j1_mode)) else $error("pin termination wrong");
	chk_pulse_map: assert property ((!hw_mode && tx_internal_term)
		|-> pulse_shape_code == ((tx_impedance == 2'h3) ? 4'h7 : {2'h0, tx_impedance}))
		else $error("pulse shape code wrong");
	chk_read_clear: assert property (flag_read |=> !irq || equalizer_out_of_range != oor_d_ff)
		else $error("event flag survived its read");
	chk_flag_cause: assert property ($rose(irq) |-> equalizer_out_of_range != oor_d_ff || oor_d_ff != oor_d2_ff)
		else $error("event flag set without status change");
	chk_eq_off: assert property (eq_idle |-> !equalizer_out_of_range)
		else $error("out of range while equalizer off");
endmodule

bind line_termination_equalizer_ctrl line_term_eq_asserts chk_u (
	.clock(clock), .nrst(nrst), .reg_rd(reg_rd), .hw_mode(hw_mode), .t1j1_mode(t1j1_mode),
	.soft_reset(soft_reset), .driver_float(driver_float), .impedance_network_pin(impedance_network_pin),
	.boost_gain_pin(boost_gain_pin), .mclk_lost(mclk_lost), .tx_clock_lost(tx_clock_lost),
	.remote_loopback(remote_loopback), .pattern_on_mclk(pattern_on_mclk), .tx_internal_term(tx_internal_term),
	.rx_internal_term(rx_internal_term), .tx_line_pair_oe(tx_line_pair_oe), .tx_powered(tx_powered),
	.equalizer_enable(equalizer_enable), .equalizer_out_of_range(equalizer_out_of_range), .irq(irq),
	.reg_addr(reg_addr), .pattern_select_pins(pattern_select_pins), .tx_impedance(tx_impedance),
	.boost_gain(boost_gain), .pulse_shape_code(pulse_shape_code));
`default_nettype wire

// file: dv/test_line_termination_equalizer_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_line_termination_equalizer_ctrl;
	logic       clock, nrst, reg_wr, reg_rd, hw_mode, t1j1_mode, soft_reset, driver_float, symbol_tick;
	logic       impedance_network_pin, boost_gain_pin, mclk_lost, tx_clock_lost, remote_loopback;
	logic       pattern_on_mclk, tx_internal_term, rx_internal_term, tx_line_pair_oe, tx_powered;
	logic       equalizer_enable, equalizer_out_of_range, irq;
	logic [1:0] pattern_select_pins, tx_impedance, rx_impedance, boost_gain;
	logic [3:0] pulse_shape_code;
	logic [4:0] eq_step;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rx_peak, level, rd_val;
	logic [5:0] pin_case [6] = '{6'b100000, 6'b010000, 6'b001000, 6'b001101, 6'b001011, 6'b000001};
	int         n_mismatch, check_count, n_tick;

	line_termination_equalizer_ctrl dut_u (.clock(clock), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hw_mode(hw_mode),
		.t1j1_mode(t1j1_mode), .soft_reset(soft_reset), .driver_float(driver_float),
		.impedance_network_pin(impedance_network_pin), .pattern_select_pins(pattern_select_pins),
		.boost_gain_pin(boost_gain_pin), .mclk_lost(mclk_lost), .tx_clock_lost(tx_clock_lost),
		.remote_loopback(remote_loopback), .pattern_on_mclk(pattern_on_mclk), .symbol_tick(symbol_tick),
		.rx_peak(rx_peak), .tx_internal_term(tx_internal_term), .tx_impedance(tx_impedance),
		.pulse_shape_code(pulse_shape_code), .rx_internal_term(rx_internal_term), .rx_impedance(rx_impedance),
		.tx_line_pair_oe(tx_line_pair_oe), .tx_powered(tx_powered), .boost_gain(boost_gain),
		.equalizer_enable(equalizer_enable), .eq_step(eq_step),
		.equalizer_out_of_range(equalizer_out_of_range), .irq(irq));
	line_side_model line_u (.clock(clock), .nrst(nrst), .level(level), .symbol_tick(symbol_tick),
		.rx_peak(rx_peak));

	// 50 MHz clock
	always #10 clock = !clock;

	// ----------------------------------------
	// Bus and compare helpers
	// ----------------------------------------
	task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		{reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clock);
		{reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 rd_val = reg_rdata;
	endtask
	// Counts received symbols until the status reaches v
	task automatic wait_oor(input logic v);
		n_tick = 0;
		#1;
		for (int i = 0; i < 2000 && equalizer_out_of_range !== v; i++) begin
			if (symbol_tick) n_tick++;
			@(posedge clock);
			#1;
		end
	endtask
	task automatic pins(input logic [4:0] v);
		@(posedge clock);
		{driver_float, mclk_lost, tx_clock_lost, remote_loopback, pattern_on_mclk} <= v;
		@(posedge clock);
		#1;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset_values;
		rd(8'h0b); chk("window_rst", 9'h08, 9'(rd_val));
		rd(8'h17); chk("loss_rst", 9'h00, 9'(rd_val));
		rd(8'h3f); chk("unmapped", 9'h00, 9'(rd_val));
	endtask
	task automatic t_codes;
		for (int c = 0; c < 8; c++) begin
			wr(8'h02, 8'(c * 9));
			#1;
			chk("tx_int", 9'(!c[2]), 9'(tx_internal_term));
			chk("tx_imp", 9'(c[1:0]), 9'(tx_impedance));
			chk("pulse", (c[1:0] == 2'h3) ? 9'h7 : 9'(c[1:0]), 9'(pulse_shape_code));
			chk("rx_int", 9'(!c[2]), 9'(rx_internal_term));
			chk("rx_imp", 9'(c[1:0]), 9'(rx_impedance));
			wr(8'h0b, 8'(c % 4));
			#1 chk("gain", 9'(c % 4), 9'(boost_gain));
		end
		rd(8'h02); chk("imp_back", 9'h3f, 9'(rd_val));
	endtask
	task automatic t_float;
		wr(8'h05, 8'h01); #1 chk("float_bit", 9'h0, 9'(tx_line_pair_oe));
		wr(8'h05, 8'h00); wr(8'h04, 8'h01);
		#1 chk("pdn_oe", 9'h0, 9'({tx_powered, tx_line_pair_oe}));
		wr(8'h04, 8'h00);
		foreach (pin_case[i]) begin
			pins(pin_case[i][5:1]); chk("oe_pins", 9'(pin_case[i][0]), 9'(tx_line_pair_oe));
		end
		wr(8'h05, 8'h01);
		soft_reset <= 1'b1;
		@(posedge clock); soft_reset <= 1'b0;
		#1 chk("oe_soft", 9'h0, 9'(tx_line_pair_oe));
		rd(8'h05); chk("float_soft", 9'h00, 9'(rd_val));
		repeat (2) @(posedge clock);
		#1 chk("oe_back", 9'h1, 9'(tx_line_pair_oe));
	endtask
	task automatic t_pins;
		// Pulse shape pins that pick the impedance value are kept by the controller outside the block
		for (int k = 0; k < 8; k++) begin
			@(posedge clock);
			{hw_mode, t1j1_mode, impedance_network_pin, boost_gain_pin} <= {1'b1, 3'(k)};
			pattern_select_pins <= 2'(k);
			@(posedge clock);
			#1 chk("tx_term", 9'(!k[1] || k[2]), 9'(tx_internal_term));
			chk("rx_term", 9'(!k[1]), 9'(rx_internal_term));
			chk("gain_pin", k[0] ? 9'h2 : 9'h0, 9'(boost_gain));
			chk("tx_on", 9'(k % 4 != 3), 9'(tx_powered));
		end
		@(posedge clock);
		{hw_mode, t1j1_mode, impedance_network_pin, boost_gain_pin, pattern_select_pins} <= 6'h00;
	endtask
	task automatic t_equalizer;
		for (int w = 0; w < 4; w++) begin
			wr(8'h0a, 8'h00); wr(8'h0b, 8'(w * 4)); wr(8'h0a, 8'h01);
			wait_oor(1'b1);
			chk("window", 9'(32 << w), 9'(n_tick));
			chk("eq_masked", 9'h2, 9'({equalizer_enable, irq}));
		end
		rd(8'h16); chk("status", 9'h01, 9'(rd_val));
		wr(8'h0a, 8'h00); rd(8'h16); chk("status_off", 9'h00, 9'(rd_val));
		wr(8'h0b, 8'h00); wr(8'h14, 8'h00); wr(8'h15, 8'h01); wr(8'h0a, 8'h01);
		wait_oor(1'b1);
		rd(8'h18); chk("flag_rise", 9'h01, 9'(rd_val));
		chk("irq_read", 9'h0, 9'(irq));
		@(posedge clock); level <= 8'h20;
		wait_oor(1'b0); chk("irq_fall", 9'h1, 9'(irq));
		chk("step", 9'h01, 9'(eq_step));
		rd(8'h17); chk("loss", 9'h01, 9'(rd_val));
		rd(8'h18); wr(8'h15, 8'h00); level <= 8'hc0;
		wait_oor(1'b1); chk("irq_rise", 9'h1, 9'(irq));
		rd(8'h18); @(posedge clock); level <= 8'h20;
		wait_oor(1'b0); chk("irq_no_fall", 9'h0, 9'(irq));
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		{clock, nrst, reg_wr, reg_rd, hw_mode, t1j1_mode, soft_reset, driver_float} = 8'h00;
		{impedance_network_pin, boost_gain_pin, mclk_lost, tx_clock_lost} = 4'h0;
		{remote_loopback, pattern_on_mclk, pattern_select_pins, reg_addr, reg_wdata} = 20'h00000;
		level = 8'hc0;
		repeat (12) @(posedge clock);
		#1 chk("oe_reset", 9'h0, 9'(tx_line_pair_oe));
		@(posedge clock);
		nrst <= 1'b1;
		t_reset_values;
		t_codes;
		t_float;
		t_pins;
		t_equalizer;
		close_out;
	end

	// Watchdog against a hang
	initial begin
		repeat (20000) @(posedge clock);
		n_mismatch++;
		close_out;
	end
endmodule
`default_nettype wire
